// ### tot_temp_offset_overtemp_throttle_out_override.sv
// Offset registers, overtemperature fan override and corrected temperature outputs.
`timescale 1ns/1ps
`include "tot_consts.svh"

module tot_temp_offset_overtemp_throttle_out_override #(
    parameter tot_pkg::tot_mag_type REVISION = 4'h0   // Arbitrary revision value.
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire tot_pkg::tot_reg_type  regAddr,
    input  wire tot_pkg::tot_reg_type  regWrData,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output tot_pkg::tot_reg_type       regRdData,
    input  wire logic                  overtempThrottleOutN,
    input  wire tot_pkg::tot_temp_type localTempRaw,
    input  wire tot_pkg::tot_temp_type remoteOneTempRaw,
    input  wire tot_pkg::tot_temp_type remoteTwoTempRaw,
    input  wire tot_pkg::tot_duty_type normalFanOneDuty,
    input  wire tot_pkg::tot_duty_type normalFanTwoDuty,
    output tot_pkg::tot_duty_type      fanOneDuty,
    output tot_pkg::tot_duty_type      fanTwoDuty,
    output tot_pkg::tot_temp_type      localTempCorrected,
    output tot_pkg::tot_temp_type      remoteOneTempCorrected,
    output tot_pkg::tot_temp_type      remoteTwoTempCorrected,
    output logic                       overtempFullSpeedEn
);
    import tot_pkg::*;

    // Power-on behaviour value as a typed constant, so that single bits can be picked from it.
    localparam tot_reg_type RESET_BEHAVIOUR = `TOT_RESET_BEHAVIOUR;

    logic        localSign;
    tot_mag_type localMagnitude;
    logic        remoteOneSign;
    tot_mag_type remoteOneMagnitude;
    logic        remoteTwoSign;
    tot_mag_type remoteTwoMagnitude;
    logic        forceFull;

    // Adds or subtracts a whole-degree magnitude and saturates to the signed byte range.
    function automatic tot_temp_type applyOffset(input tot_temp_type t,
                                                 input logic        s,
                                                 input tot_mag_type m);
        logic signed [9:0] wide;
        begin
            wide = 10'sh000;
            if (s)
                wide = $signed({{2{t[7]}}, t}) - $signed({6'h00, m});
            else
                wide = $signed({{2{t[7]}}, t}) + $signed({6'h00, m});
            if (wide > 10'sh07F)
                applyOffset = 8'sh7F;
            else if (wide < -10'sh080)
                applyOffset = -8'sh80;
            else
                applyOffset = wide[7:0];
        end
    endfunction : applyOffset

    // Offset register writes; the local magnitude ignores writes, unused bits are not kept.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            localSign          <= 1'b0;
            localMagnitude     <= `TOT_RESET_MAGNITUDE;
            remoteOneSign      <= 1'b0;
            remoteOneMagnitude <= `TOT_RESET_MAGNITUDE;
            remoteTwoSign      <= 1'b0;
            remoteTwoMagnitude <= `TOT_RESET_MAGNITUDE;
        end
        else if (regWrite)
        begin
            unique case (regAddr)
                `TOT_ADDR_LOCAL_CORR:
                begin
                    localSign <= regWrData[`TOT_SIGN_BIT];
                end
                `TOT_ADDR_REMOTE_ONE:
                begin
                    remoteOneSign      <= regWrData[`TOT_SIGN_BIT];
                    remoteOneMagnitude <= regWrData[`TOT_MAG_MSB:0];
                end
                `TOT_ADDR_REMOTE_TWO:
                begin
                    remoteTwoSign      <= regWrData[`TOT_SIGN_BIT];
                    remoteTwoMagnitude <= regWrData[`TOT_MAG_MSB:0];
                end
                default:
                begin
                    localSign <= localSign;
                end
            endcase
        end
    end

    // Override enable; only bit 7 of the behaviour register is writable.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            overtempFullSpeedEn <= RESET_BEHAVIOUR[`TOT_FULL_SPEED_BIT];
        else if (regWrite && regAddr == `TOT_ADDR_BEHAVIOUR)
            overtempFullSpeedEn <= regWrData[`TOT_FULL_SPEED_BIT];
    end

    // Registered read data, one cycle after the read strobe; unmapped offsets read zero.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            regRdData <= `TOT_READ_ZERO;
        else if (regRead)
        begin
            unique case (regAddr)
                `TOT_ADDR_LOCAL_CORR: regRdData <= {localSign, 3'h0, localMagnitude};
                `TOT_ADDR_REMOTE_ONE: regRdData <= {remoteOneSign, 3'h0, remoteOneMagnitude};
                `TOT_ADDR_REMOTE_TWO: regRdData <= {remoteTwoSign, 3'h0, remoteTwoMagnitude};
                `TOT_ADDR_BEHAVIOUR:  regRdData <= {overtempFullSpeedEn, 3'h0, REVISION};
                default:              regRdData <= `TOT_READ_ZERO;
            endcase
        end
    end

    // Corrected readings feed limit comparison and fan control downstream.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            localTempCorrected     <= `TOT_RESET_TEMP;
            remoteOneTempCorrected <= `TOT_RESET_TEMP;
            remoteTwoTempCorrected <= `TOT_RESET_TEMP;
        end
        else
        begin
            localTempCorrected     <= applyOffset(localTempRaw, localSign, localMagnitude);
            remoteOneTempCorrected <= applyOffset(remoteOneTempRaw, remoteOneSign,
                                                  remoteOneMagnitude);
            remoteTwoTempCorrected <= applyOffset(remoteTwoTempRaw, remoteTwoSign,
                                                  remoteTwoMagnitude);
        end
    end

    // Full speed is forced only when enabled and the overtemperature output is low.
    assign forceFull = overtempFullSpeedEn && !overtempThrottleOutN;

    // Fan duty outputs.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            fanOneDuty <= `TOT_RESET_DUTY;
            fanTwoDuty <= `TOT_RESET_DUTY;
        end
        else if (forceFull)
        begin
            fanOneDuty <= `TOT_FULL_DUTY;
            fanTwoDuty <= `TOT_FULL_DUTY;
        end
        else
        begin
            fanOneDuty <= normalFanOneDuty;
            fanTwoDuty <= normalFanTwoDuty;
        end
    end

    // Checks.
    sequence overtempActive;
        overtempFullSpeedEn && !overtempThrottleOutN;
    endsequence

    sequence behaviourRead;
        regRead && regAddr == `TOT_ADDR_BEHAVIOUR;
    endsequence

    sequence releaseThenBehaviourRead;
        rst ##1 (!rst && !regWrite) ##1 (!rst && !regWrite) ##0 behaviourRead;
    endsequence

    full_speed_a: assert property (@(posedge ref_clk) disable iff (rst)
        overtempActive |=> fanOneDuty == 4'hF && fanTwoDuty == 4'hF)
        else $error("Fans not at full speed during overtemperature.");

    silent_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
        !overtempFullSpeedEn |=> fanOneDuty == $past(normalFanOneDuty)
                                 && fanTwoDuty == $past(normalFanTwoDuty))
        else $error("Fans forced although override is off.");

    behaviour_reset_a: assert property (@(posedge ref_clk)
        releaseThenBehaviourRead |=> regRdData == (RESET_BEHAVIOUR | {4'h0, REVISION}))
        else $error("Behaviour register not 80H after reset.");

    revision_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
        behaviourRead |=> regRdData[3:0] == REVISION && regRdData[6:4] == 3'h0)
        else $error("Revision nibble wrong.");

    local_mag_a: assert property (@(posedge ref_clk) disable iff (rst)
        regRead && regAddr == `TOT_ADDR_LOCAL_CORR |=> regRdData[6:0] == 7'h00)
        else $error("Local magnitude changed by a write.");

    local_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> localTempCorrected == $past(localTempRaw))
        else $error("Local reading altered with zero magnitude.");

    remote_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        remoteOneSign && remoteOneTempRaw >= -8'sd113
        |=> remoteOneTempCorrected
            == $past(remoteOneTempRaw) - $signed({4'h0, $past(remoteOneMagnitude)}))
        else $error("Remote one subtraction wrong.");

    remote_two_a: assert property (@(posedge ref_clk) disable iff (rst)
        !remoteTwoSign && remoteTwoTempRaw <= 8'sd112
        |=> remoteTwoTempCorrected
            == $past(remoteTwoTempRaw) + $signed({4'h0, $past(remoteTwoMagnitude)}))
        else $error("Remote two addition wrong.");

    unused_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        regRead && (regAddr == `TOT_ADDR_REMOTE_ONE || regAddr == `TOT_ADDR_REMOTE_TWO)
        |=> regRdData[6:4] == 3'h0)
        else $error("Unused remote bits not zero.");

    offset_reset_a: assert property (@(posedge ref_clk)
        rst |=> !remoteOneSign && remoteOneMagnitude == 4'h0
                && !remoteTwoSign && remoteTwoMagnitude == 4'h0 && !localSign)
        else $error("Offset registers not zero after reset.");

endmodule : tot_temp_offset_overtemp_throttle_out_override

// ### tot_consts.svh
// Register offsets, field positions, reset values and fan constants of the offset block.
`ifndef TOT_CONSTS_SVH
`define TOT_CONSTS_SVH

`define TOT_ADDR_LOCAL_CORR     8'h0D
`define TOT_ADDR_REMOTE_ONE     8'h0E
`define TOT_ADDR_REMOTE_TWO     8'h0F
`define TOT_ADDR_BEHAVIOUR      8'h3F

`define TOT_SIGN_BIT            7
`define TOT_FULL_SPEED_BIT      7
`define TOT_MAG_MSB             3

`define TOT_RESET_CORRECTION    8'h00
`define TOT_RESET_BEHAVIOUR     8'h80
`define TOT_RESET_MAGNITUDE     4'h0
`define TOT_RESET_DUTY          4'h0
`define TOT_RESET_TEMP          8'h00
`define TOT_READ_ZERO           8'h00
`define TOT_FULL_DUTY           4'hF

`endif

// ### tot_pkg.sv
// Types shared by the temperature offset and overtemperature override block.
package tot_pkg;

    typedef logic [7:0]        tot_reg_type;
    typedef logic signed [7:0] tot_temp_type;
    typedef logic [3:0]        tot_mag_type;
    typedef logic [3:0]        tot_duty_type;

endpackage : tot_pkg

// ### tot_host_model.sv
// Host side model that issues register writes and reads on the strobe port.
`timescale 1ns/1ps

module tot_host_model (
    input  wire logic                 ref_clk,
    output tot_pkg::tot_reg_type      regAddr,
    output tot_pkg::tot_reg_type      regWrData,
    output logic                      regWrite,
    output logic                      regRead,
    input  wire tot_pkg::tot_reg_type regRdData
);
    import tot_pkg::*;

    // Idle bus values at time zero; strobes low so nothing is taken.
    initial
    begin
        regAddr   = 8'hA5;
        regWrData = 8'h5A;
        regWrite  = 1'b0;
        regRead   = 1'b0;
    end

    // One write strobe, held across one rising edge, then released lines invert.
    task automatic wr(input tot_reg_type a, input tot_reg_type w);
        @(negedge ref_clk);
        regAddr   <= a;
        regWrData <= w;
        regWrite  <= 1'b1;
        @(negedge ref_clk);
        regWrite  <= 1'b0;
        regAddr   <= ~a;
        regWrData <= ~w;
    endtask : wr

    // One read strobe; the data is taken once the registered answer has settled.
    task automatic rd(input tot_reg_type a, output tot_reg_type d);
        @(negedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(negedge ref_clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(negedge ref_clk);
        d = regRdData;
    endtask : rd

endmodule : tot_host_model

// ### tb_tot_temp_offset_overtemp_throttle_out_override.sv
// Self-checking bench for the offset registers and the overtemperature fan override.
`timescale 1ns/1ps
`include "tot_consts.svh"

module tb_tot_temp_offset_overtemp_throttle_out_override;
    import tot_pkg::*;
    typedef struct {tot_reg_type a; tot_reg_type w; tot_reg_type r;
                    tot_temp_type raw; tot_temp_type c; int ch;} tot_row_type;
    logic         ref_clk = 1'b0;
    logic         rst     = 1'b1;
    logic         regWrite, regRead, overtempFullSpeedEn;
    logic         throttleN = 1'b1;
    tot_reg_type  regAddr, regWrData, regRdData, d;
    tot_temp_type tRaw = 8'sh00;
    tot_temp_type corr [3];
    tot_duty_type n1 = 4'h3;
    tot_duty_type n2 = 4'h5;
    tot_duty_type f1, f2;
    int           nMismatch = 0;
    int           testsRun  = 0;
    // Channel 0 local, 1 remote one, 2 remote two, 3 no temperature check.
    tot_row_type rows [7] = '{
        '{8'h0E, 8'hF5, 8'h85, 8'sh1E, 8'sh19, 1}, '{8'h0E, 8'h0F, 8'h0F, 8'sh1E, 8'sh2D, 1},
        '{8'h0F, 8'h8F, 8'h8F, 8'sh88, 8'sh80, 2}, '{8'h0F, 8'h7A, 8'h0A, 8'sh78, 8'sh7F, 2},
        '{8'h0D, 8'hFF, 8'h80, 8'sh14, 8'sh14, 0}, '{8'h3F, 8'h0F, 8'h00, 8'sh00, 8'sh00, 3},
        '{8'h10, 8'h55, 8'h00, 8'sh00, 8'sh00, 3}};

    // Free-running 100 MHz clock.
    always #5 ref_clk = ~ref_clk;

    tot_temp_offset_overtemp_throttle_out_override tot_temp_offset_overtemp_throttle_out_override_i (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .overtempThrottleOutN(throttleN), .localTempRaw(tRaw),
        .remoteOneTempRaw(tRaw), .remoteTwoTempRaw(tRaw),
        .normalFanOneDuty(n1), .normalFanTwoDuty(n2), .fanOneDuty(f1), .fanTwoDuty(f2),
        .localTempCorrected(corr[0]), .remoteOneTempCorrected(corr[1]),
        .remoteTwoTempCorrected(corr[2]), .overtempFullSpeedEn(overtempFullSpeedEn));

    tot_host_model tot_host_model_i (
        .ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));

    // Compare tasks count every check and report a mismatch at once.
    task automatic chk8(input tot_reg_type g, input tot_reg_type e);
        testsRun++;
        if (g !== e)
        begin
            nMismatch++;
            $display("wrong value at %0t: byte %h, expected %h", $time, g, e);
        end
    endtask : chk8

    task automatic chk4(input tot_duty_type g, input tot_duty_type e);
        testsRun++;
        if (g !== e)
        begin
            nMismatch++;
            $display("wrong value at %0t: duty %h, expected %h", $time, g, e);
        end
    endtask : chk4

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Main sequence: reset values, table rows, fan override, reset in mid-run.
    initial
    begin
        cyc(20);
        rst = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            tot_host_model_i.rd(tot_reg_type'(8'h0D + k), d);
            chk8(d, `TOT_RESET_CORRECTION);
        end
        tot_host_model_i.rd(`TOT_ADDR_BEHAVIOUR, d);
        chk8(d, `TOT_RESET_BEHAVIOUR);
        $display("test reset values done");
        foreach (rows[i])
        begin
            tRaw = rows[i].raw;
            tot_host_model_i.wr(rows[i].a, rows[i].w);
            tot_host_model_i.rd(rows[i].a, d);
            chk8(d, rows[i].r);
            if (rows[i].ch < 3)
                chk8(corr[rows[i].ch], rows[i].c);
        end
        $display("test register rows done");
        tot_host_model_i.wr(`TOT_ADDR_BEHAVIOUR, 8'h80);
        throttleN = 1'b0;
        cyc(2);
        chk4(f1, `TOT_FULL_DUTY);
        chk4(f2, `TOT_FULL_DUTY);
        throttleN = 1'b1;
        cyc(2);
        chk4(f1, n1);
        tot_host_model_i.wr(`TOT_ADDR_BEHAVIOUR, 8'h00);
        throttleN = 1'b0;
        cyc(2);
        chk8({7'h00, overtempFullSpeedEn}, 8'h00);
        chk4(f2, n2);
        $display("test fan override done");
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        tot_host_model_i.rd(`TOT_ADDR_BEHAVIOUR, d);
        chk8(d, `TOT_RESET_BEHAVIOUR);
        tot_host_model_i.rd(`TOT_ADDR_REMOTE_TWO, d);
        chk8(d, `TOT_RESET_CORRECTION);
        $display("test mid-run reset done");
        stop_test();
    end

endmodule : tb_tot_temp_offset_overtemp_throttle_out_override
